// *** logic/ipcb_priority_bank.sv ***
// Interrupt priority configuration bank with its register front end
// Notes on behaviour
// RL1: A field holds the level directly, 111 is level 7 down to 001 level 1.
// RL2: A field of 000 disables the source; its request never goes onward.
// RL3: Unused bits and separator bits ignore writes and read as zero.
// RL4: Each field resets to 100 and stays readable and writable.
// RL5: Register seven: uart2 tx 14-12, rx 10-8, ext irq2 6-4, timer5 2-0.
// RL6: Register eight: can event 14-12, can rx 10-8, serial2 6-4, err 2-0.
// RL7: Without the CAN controller both CAN sources stay disabled.
// RL8: Register nine holds only dma channel 3 at bits 2-0.
// RL9: Register eleven: dma channel 4 at 10-8, parallel port at 6-4.
// RL10: Register fourteen: quad decoder 1 at 10-8, pulse gen 1 at 6-4.
// RL11: Register fifteen: fault a 14-12, calendar 10-8, dma channel 5 6-4.
// RL12: After reset every source here sits at level 4, except both CAN sources without the CAN controller.
// RL13: Software wanting no levels writes one nonzero value everywhere.
// RL14: Field values reach the arbiter continuously, from the next cycle.
`timescale 1ns/1ps
`include "ipcb_defines.svh"
module ipcb_priority_bank #(
  parameter bit HAS_CAN = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [`IPCB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`IPCB_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`IPCB_NUM_SRC-1:0] srcRequest,
  output ipcb_pkg::ipcb_arb_t arbOut,
  output logic [`IPCB_NUM_SRC-1:0] gatedRequest
);

  localparam int NSRC = `IPCB_NUM_SRC;
  localparam logic [NSRC-1:0][2:0] SRC_REG = `IPCB_SRC_REG_TABLE;
  localparam logic [NSRC-1:0][3:0] SRC_POS = `IPCB_SRC_POS_TABLE;
  // Sources present on this variant
  localparam logic [NSRC-1:0] SRC_PRESENT =
    HAS_CAN ? {NSRC{1'b1}} : ~`IPCB_CAN_SRC_MASK;

  ipcb_pkg::ipcb_bank_state_t st;
  ipcb_pkg::ipcb_bank_state_t next_st;
  ipcb_pkg::ipcb_wr_t wr;
  ipcb_pkg::ipcb_reg_t rdTarget;
  logic [15:0] rdData;

  ////////////////////////////////////////////////////////////////////////
  // Byte lane that carries a field starting at pos
  function automatic logic laneOn(input logic [3:0] pos,
                                  input logic [1:0] strb);
    return (pos >= `IPCB_UPPER_LANE_POS) ? strb[1] : strb[0];
  endfunction

  // Readback built from fields, or from request bits for the status word, so unused bits read zero
  function automatic logic [15:0] readReg(
    input ipcb_pkg::ipcb_reg_t r,
    input ipcb_pkg::ipcb_prio_vec_t p,
    input logic [NSRC-1:0] req
  );
    logic [15:0] v;
    v = 16'h0000;
    if (r == ipcb_pkg::IPCB_REG_REQUEST_STATUS) begin
      v = req;
    end else begin
      for (int s = 0; s < NSRC; s++) begin
        if (SRC_REG[s] == r) begin
          v[SRC_POS[s] +: 3] = p[s]; // RL3 RL5 RL6 RL8 RL9 RL10 RL11
        end
      end
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register bus front end
  ipcb_axil_slave u_axil (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr(wr),
    .rdTarget(rdTarget),
    .rdData(rdData)
  );

  assign rdData = readReg(rdTarget, st.prio, gatedRequest);

  ////////////////////////////////////////////////////////////////////////
  // Field updates; only the three bits of each field are stored
  always_comb begin
    next_st = st;
    if (wr.en) begin
      for (int s = 0; s < NSRC; s++) begin
        if ((SRC_REG[s] == wr.target) && laneOn(SRC_POS[s], wr.strb)) begin
          next_st.prio[s] = wr.data[SRC_POS[s] +: 3]; // RL3 RL4
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.prio <= {NSRC{`IPCB_PRIO_RESET}}; // RL4 RL12
    end else begin
      st <= next_st; // RL14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Arbiter view; a missing CAN block pins its level to off whatever
  // software wrote, while the stored field still reads back
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    assign arbOut.level[g] =
      SRC_PRESENT[g] ? st.prio[g] : `IPCB_PRIO_OFF; // RL1 RL7 RL14
    assign arbOut.enabled[g] =
      (arbOut.level[g] != `IPCB_PRIO_OFF); // RL2 RL7
    assign gatedRequest[g] = srcRequest[g] && arbOut.enabled[g]; // RL2
  end

endmodule // ipcb_priority_bank

// *** shared/ipcb_defines.svh ***
// Offsets, field positions, reset values and tables of the priority bank
`ifndef IPCB_DEFINES_SVH
`define IPCB_DEFINES_SVH

`define IPCB_ADDR_W 8
`define IPCB_NUM_SRC 16
`define IPCB_FIELD_W 3

// Byte addresses of the registers
`define IPCB_OFS_UART2_EXT2_TIMER5 8'h1c
`define IPCB_OFS_CAN_SPI2 8'h20
`define IPCB_OFS_DMA_CH3 8'h24
`define IPCB_OFS_DMA_CH4_PARALLEL 8'h2c
`define IPCB_OFS_QUAD1_PWM1 8'h38
`define IPCB_OFS_FAULT_RTC_DMA_CH5 8'h3c
`define IPCB_OFS_REQUEST_STATUS 8'h40

// Register codes used by the decoder and the source tables
`define IPCB_REGC_NONE 3'h0
`define IPCB_REGC_UART2_EXT2_TIMER5 3'h1
`define IPCB_REGC_CAN_SPI2 3'h2
`define IPCB_REGC_DMA_CH3 3'h3
`define IPCB_REGC_DMA_CH4_PARALLEL 3'h4
`define IPCB_REGC_QUAD1_PWM1 3'h5
`define IPCB_REGC_FAULT_RTC_DMA_CH5 3'h6
`define IPCB_REGC_REQUEST_STATUS 3'h7

// Per source, listed from source 15 down to source 0
`define IPCB_SRC_REG_TABLE {3'h6, 3'h6, 3'h6, 3'h5, 3'h5, 3'h4, 3'h4, \
  3'h3, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1}
`define IPCB_SRC_POS_TABLE {4'h4, 4'h8, 4'hc, 4'h4, 4'h8, 4'h4, 4'h8, \
  4'h0, 4'h0, 4'h4, 4'h8, 4'hc, 4'h0, 4'h4, 4'h8, 4'hc}

`define IPCB_PRIO_RESET 3'h4
`define IPCB_PRIO_OFF 3'h0
`define IPCB_CAN_SRC_MASK 16'h0030
`define IPCB_UPPER_LANE_POS 4'h8

`define IPCB_RESP_OKAY 2'h0
`define IPCB_RESP_DECERR 2'h3

`endif

// *** shared/ipcb_pkg.sv ***
// Types and address decoder shared by the priority bank files
`include "ipcb_defines.svh"
package ipcb_pkg;

  typedef enum logic [2:0] {
    IPCB_REG_NONE = `IPCB_REGC_NONE,
    IPCB_REG_UART2_EXT2_TIMER5 = `IPCB_REGC_UART2_EXT2_TIMER5,
    IPCB_REG_CAN_SPI2 = `IPCB_REGC_CAN_SPI2,
    IPCB_REG_DMA_CH3 = `IPCB_REGC_DMA_CH3,
    IPCB_REG_DMA_CH4_PARALLEL = `IPCB_REGC_DMA_CH4_PARALLEL,
    IPCB_REG_QUAD1_PWM1 = `IPCB_REGC_QUAD1_PWM1,
    IPCB_REG_FAULT_RTC_DMA_CH5 = `IPCB_REGC_FAULT_RTC_DMA_CH5,
    IPCB_REG_REQUEST_STATUS = `IPCB_REGC_REQUEST_STATUS
  } ipcb_reg_t;

  typedef enum logic [1:0] {
    IPCB_WR_COLLECT = 2'h0,
    IPCB_WR_COMMIT = 2'h1,
    IPCB_WR_RESP = 2'h3
  } ipcb_wr_state_t;

  typedef enum logic {
    IPCB_RD_IDLE = 1'h0,
    IPCB_RD_RESP = 1'h1
  } ipcb_rd_state_t;

  typedef logic [`IPCB_NUM_SRC-1:0][`IPCB_FIELD_W-1:0] ipcb_prio_vec_t;

  typedef struct packed {
    logic en;
    ipcb_reg_t target;
    logic [15:0] data;
    logic [1:0] strb;
  } ipcb_wr_t;

  typedef struct packed {
    ipcb_prio_vec_t level;
    logic [`IPCB_NUM_SRC-1:0] enabled;
  } ipcb_arb_t;

  typedef struct packed {
    ipcb_prio_vec_t prio;
  } ipcb_bank_state_t;

  typedef struct packed {
    ipcb_wr_state_t wrState;
    logic awHeld;
    logic wHeld;
    ipcb_reg_t awTarget;
    logic [15:0] wData;
    logic [1:0] wStrb;
    logic [1:0] bresp;
    ipcb_rd_state_t rdState;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipcb_axi_state_t;

  function automatic ipcb_reg_t ipcb_decode(
    input logic [`IPCB_ADDR_W-1:0] addr
  );
    ipcb_reg_t r;
    r = IPCB_REG_NONE;
    case ({addr[`IPCB_ADDR_W-1:2], 2'h0})
      `IPCB_OFS_UART2_EXT2_TIMER5: r = IPCB_REG_UART2_EXT2_TIMER5;
      `IPCB_OFS_CAN_SPI2: r = IPCB_REG_CAN_SPI2;
      `IPCB_OFS_DMA_CH3: r = IPCB_REG_DMA_CH3;
      `IPCB_OFS_DMA_CH4_PARALLEL: r = IPCB_REG_DMA_CH4_PARALLEL;
      `IPCB_OFS_QUAD1_PWM1: r = IPCB_REG_QUAD1_PWM1;
      `IPCB_OFS_FAULT_RTC_DMA_CH5: r = IPCB_REG_FAULT_RTC_DMA_CH5;
      `IPCB_OFS_REQUEST_STATUS: r = IPCB_REG_REQUEST_STATUS;
      default: r = IPCB_REG_NONE;
    endcase
    return r;
  endfunction

endpackage

// *** logic/ipcb_axil_slave.sv ***
// AXI4-Lite slave front end of the priority bank
`timescale 1ns/1ps
`include "ipcb_defines.svh"
module ipcb_axil_slave (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [`IPCB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`IPCB_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output ipcb_pkg::ipcb_wr_t wr,
  output ipcb_pkg::ipcb_reg_t rdTarget,
  input wire logic [15:0] rdData
);

  ipcb_pkg::ipcb_axi_state_t st;
  ipcb_pkg::ipcb_axi_state_t next_st;
  logic inCollect;

  ////////////////////////////////////////////////////////////////////////
  // Handshakes; protection bits carry no meaning here
  assign inCollect = (st.wrState == ipcb_pkg::IPCB_WR_COLLECT);
  assign s_axi_awready = inCollect && !st.awHeld;
  assign s_axi_wready = inCollect && !st.wHeld;
  assign s_axi_bvalid = (st.wrState == ipcb_pkg::IPCB_WR_RESP);
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = (st.rdState == ipcb_pkg::IPCB_RD_IDLE);
  assign s_axi_rvalid = (st.rdState == ipcb_pkg::IPCB_RD_RESP);
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign rdTarget = ipcb_pkg::ipcb_decode(s_axi_araddr);

  // One-cycle write strobe; unmapped targets never reach the bank
  assign wr.en = (st.wrState == ipcb_pkg::IPCB_WR_COMMIT) &&
                 (st.awTarget != ipcb_pkg::IPCB_REG_NONE);
  assign wr.target = st.awTarget;
  assign wr.data = st.wData;
  assign wr.strb = st.wStrb;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    case (st.wrState)
      ipcb_pkg::IPCB_WR_COLLECT: begin
        if (s_axi_awvalid && !st.awHeld) begin
          next_st.awHeld = 1'b1;
          next_st.awTarget = ipcb_pkg::ipcb_decode(s_axi_awaddr);
        end
        if (s_axi_wvalid && !st.wHeld) begin
          next_st.wHeld = 1'b1;
          next_st.wData = s_axi_wdata[15:0];
          next_st.wStrb = s_axi_wstrb[1:0];
        end
        if (next_st.awHeld && next_st.wHeld) begin
          next_st.wrState = ipcb_pkg::IPCB_WR_COMMIT;
        end
      end
      ipcb_pkg::IPCB_WR_COMMIT: begin
        next_st.awHeld = 1'b0;
        next_st.wHeld = 1'b0;
        next_st.bresp = (st.awTarget == ipcb_pkg::IPCB_REG_NONE) ?
                        `IPCB_RESP_DECERR : `IPCB_RESP_OKAY;
        next_st.wrState = ipcb_pkg::IPCB_WR_RESP;
      end
      ipcb_pkg::IPCB_WR_RESP: begin
        if (s_axi_bready) begin
          next_st.wrState = ipcb_pkg::IPCB_WR_COLLECT;
        end
      end
      default: next_st.wrState = ipcb_pkg::IPCB_WR_COLLECT;
    endcase
    case (st.rdState)
      ipcb_pkg::IPCB_RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_st.rdState = ipcb_pkg::IPCB_RD_RESP;
          next_st.rdata = {16'h0000, rdData};
          next_st.rresp = (rdTarget == ipcb_pkg::IPCB_REG_NONE) ?
                          `IPCB_RESP_DECERR : `IPCB_RESP_OKAY;
        end
      end
      ipcb_pkg::IPCB_RD_RESP: begin
        if (s_axi_rready) begin
          next_st.rdState = ipcb_pkg::IPCB_RD_IDLE;
        end
      end
      default: next_st.rdState = ipcb_pkg::IPCB_RD_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // ipcb_axil_slave

// *** testbench/ipcb_monitor.sv ***
// Port checker for the priority bank
`timescale 1ns/1ps
`include "ipcb_defines.svh"
module ipcb_monitor #(
  parameter bit HAS_CAN = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [15:0] srcRequest,
  input wire ipcb_pkg::ipcb_arb_t arbOut,
  input wire logic [15:0] gatedRequest
);
  logic [15:0] nonZero;
  logic statusRead;
  // Status word carries request bits, so field gaps do not apply to it
  always_ff @(posedge ref_clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      statusRead <= ({s_axi_araddr[7:2], 2'h0} ==
                     `IPCB_OFS_REQUEST_STATUS);
    end
  end
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      nonZero[i] = |arbOut.level[i];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  a_enable_level: assert property (arbOut.enabled == nonZero)
    else $error("enable flags disagree with levels");
  a_request_gate: assert property (
    gatedRequest == (srcRequest & arbOut.enabled))
    else $error("gated request wrong");
  a_can_absent: assert property (
    !HAS_CAN |-> arbOut.level[4] == 3'h0 && arbOut.level[5] == 3'h0)
    else $error("absent CAN source has a level");
  a_reset_level: assert property ($rose(rst_n) |-> arbOut.level ==
    {{10{3'h4}}, {2{HAS_CAN ? 3'h4 : 3'h0}}, {4{3'h4}}})
    else $error("level after reset not 4");
  a_unused_zero: assert property (
    s_axi_rvalid && !statusRead |-> (s_axi_rdata & 32'hffff8888) == 32'h0)
    else $error("unused read bit set");
  a_write_latency: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_level_update: assert property (
    $changed(arbOut.level) |-> $rose(s_axi_bvalid))
    else $error("level moved without a write");
  a_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // ipcb_monitor

// *** testbench/tb_top.sv ***
// Self-checking bench for the priority bank
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h0;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [15:0] srcRequest = 16'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] gatedRequest;
  ipcb_pkg::ipcb_arb_t arbOut;
  int failCount = 0;
  int checkCount = 0;
  logic [2:0] mdl [16];
  // Register index and field low bit of each source
  int sreg [16] = '{0,0,0,0,1,1,1,1,2,3,3,4,4,5,5,5};
  int spos [16] = '{12,8,4,0,12,8,4,0,0,8,4,8,4,12,8,4};
  logic [7:0] radr [6] = '{8'h1c,8'h20,8'h24,8'h2c,8'h38,8'h3c};
  always #50 ref_clk = ~ref_clk;
  // Variant without CAN, so the forced-off path is exercised
  ipcb_priority_bank #(.HAS_CAN(1'b0)) ipcb_priority_bank_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .srcRequest(srcRequest), .arbOut(arbOut),
    .gatedRequest(gatedRequest));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] expWord(int k);
    logic [31:0] w;
    w = 32'h0;
    for (int s = 0; s < 16; s++) begin
      if (sreg[s] == k) w[spos[s]+:3] = mdl[s];
    end
    return w;
  endfunction
  function automatic ipcb_pkg::ipcb_arb_t expArb();
    ipcb_pkg::ipcb_arb_t e;
    for (int s = 0; s < 16; s++) begin
      e.level[s] = (s == 4 || s == 5) ? 3'h0 : mdl[s];
      e.enabled[s] = e.level[s] != 3'h0;
    end
    return e;
  endfunction
  task automatic cmpVal(input logic [63:0] got, input logic [63:0] exp);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpResp(input logic [1:0] got, input logic [1:0] exp);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic axiWrite(input logic [7:0] a, input logic [15:0] d,
      input logic [1:0] s, output logic [1:0] r);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {16'h0, d};
    wstrb <= {2'h0, s};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic checkAll();
    logic [31:0] d;
    logic [1:0] r;
    ipcb_pkg::ipcb_arb_t e;
    for (int k = 0; k < 6; k++) begin
      axiRead(radr[k], d, r);
      cmpResp(r, 2'h0);
      cmpVal({32'h0, d}, {32'h0, expWord(k)});
    end
    e = expArb();
    cmpVal(arbOut, e);
    cmpVal({48'h0, gatedRequest}, {48'h0, srcRequest & e.enabled});
    axiRead(8'h40, d, r);
    cmpResp(r, 2'h0);
    cmpVal({32'h0, d}, {48'h0, srcRequest & e.enabled});
  endtask
  task automatic wrChk(input int k, input logic [15:0] d,
      input logic [1:0] s);
    logic [1:0] r;
    srcRequest <= 16'($urandom());
    axiWrite(radr[k], d, s, r);
    cmpResp(r, 2'h0);
    for (int i = 0; i < 16; i++) begin
      if (sreg[i] == k && s[spos[i] / 8]) mdl[i] = d[spos[i]+:3];
    end
    checkAll();
  endtask
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(32'hab31));
    for (int i = 0; i < 16; i++) mdl[i] = 3'h4;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    checkAll();
    $display("reset test done");
    for (int k = 0; k < 6; k++) begin
      wrChk(k, 16'hffff, 2'h3);
      wrChk(k, 16'h0000, 2'h3);
    end
    $display("boundary test done");
    for (int k = 0; k < 6; k++) begin
      wrChk(k, 16'h7777, 2'h3);
    end
    $display("uniform test done");
    for (int n = 0; n < 40; n++) begin
      wrChk($urandom_range(5), 16'($urandom()), 2'($urandom()));
    end
    $display("random test done");
    axiWrite(8'h00, 16'hffff, 2'h3, r);
    cmpResp(r, 2'h3);
    axiRead(8'h00, d, r);
    cmpResp(r, 2'h3);
    cmpVal({32'h0, d}, 64'h0);
    axiWrite(8'h40, 16'hffff, 2'h3, r);
    cmpResp(r, 2'h0);
    checkAll();
    $display("unmapped test done");
    printVerdict();
  end
  // Generous margin over roughly 1500 cycles of traffic
  initial begin
    #500us;
    failCount++;
    printVerdict();
  end
endmodule // tb_top
bind ipcb_priority_bank ipcb_monitor #(.HAS_CAN(HAS_CAN)) ipcb_monitor_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .srcRequest(srcRequest), .arbOut(arbOut), .gatedRequest(gatedRequest));
